// >>> bpr_remote_port.sv
// parallel negative-logic remote-control port with apb register access
//
// The implementer's own choices: the APB interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bpr_remote_port (
	input  wire logic              pclk,
	input  wire logic              presetn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	output var  logic [31:0]       prdata,
	output var  logic              pready,
	output var  logic              pslverr,
	input  wire bpr_pkg::bpr_pins_s pins_n,
	input  wire logic              trig_n,
	input  wire logic              limiter_active,
	output var  bpr_pkg::bpr_setup_s setup,
	output var  logic              scan_run,
	output var  logic              limit_flag_n,
	output var  logic              output_on_flag_n,
	output var  logic              irq
);
	import bpr_pkg::*;

	bpr_pins_s          pin_q;
	bpr_pins_s          pin_pos;
	bpr_setup_s         setup_d;
	logic [ST_W-1:0]    status_q;
	logic [ST_W-1:0]    status_d;
	logic [ST_W-1:0]    status_set;
	logic [ST_W-1:0]    status_clr;
	logic [ST_W-1:0]    mask_q;
	logic [ST_W-1:0]    mask_d;
	logic               remote_q;
	logic               limit_q;
	logic               trig_evt;
	logic [N_DIGITS-1:0] digit_bad;
	logic               bcd_bad;
	logic               load;
	logic               setup_changed;
	logic               limit_now;

	// apb decode
	logic        apb_setup;
	logic        apb_access;
	logic        wr_en;
	logic        hit_status;
	logic        hit_mask;
	logic        hit_level;
	logic        hit_setup;
	logic        hit_ctrl;
	logic        hit_any;
	logic [31:0] rd_mux;
	logic [31:0] setup_word;

	assign apb_setup  = psel && !penable;
	assign apb_access = psel && penable && pready;
	assign wr_en      = apb_access && pwrite && !pslverr;
	assign hit_status = (paddr == REG_STATUS);
	assign hit_mask   = (paddr == REG_MASK);
	assign hit_level  = (paddr == REG_LEVEL);
	assign hit_setup  = (paddr == REG_SETUP);
	assign hit_ctrl   = (paddr == REG_CTRL);
	assign hit_any    = hit_status | hit_mask | hit_level | hit_setup | hit_ctrl;

	// setup readback word
	always_comb begin
		setup_word                           = '0;
		setup_word[SU_FUNC]                  = setup.func_current;
		setup_word[SU_RANGE +: 2]            = setup.range;
		setup_word[SU_NEG]                   = setup.negative;
		setup_word[SU_DIV]                   = setup.divider_on;
		setup_word[SU_OPER]                  = setup.operate;
		setup_word[SU_SCAN]                  = scan_run;
		setup_word[SU_REMOTE]                = remote_q;
		setup_word[SU_VLIM +: VLIM_W]        = setup.vlimit_v;
		setup_word[SU_ILIM +: ILIM_W]        = setup.ilimit_ma;
	end

	// read data select, captured in the setup cycle
	assign rd_mux = hit_status ? {{(32-ST_W){1'b0}}, status_q} :
	                hit_mask   ? {{(32-ST_W){1'b0}}, mask_q} :
	                hit_level  ? {{(32-LEVEL_W){1'b0}}, setup.level} :
	                hit_setup  ? setup_word :
	                hit_ctrl   ? {31'h0, remote_q} : 32'h0;

	// apb answer flops: ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else begin
			pready  <= apb_setup;
			pslverr <= apb_setup && !hit_any;
			prdata  <= apb_setup ? rd_mux : prdata;
		end
	end

	// connector lines are taken one clock late; inversion makes logical ones
	assign pin_pos = ~pin_q;

	// one validity check per bcd digit
	genvar g;
	generate
		for (g = 0; g < N_DIGITS; g++) begin : g_digit
			assign digit_bad[g] = pin_pos.level_n[4*g +: 4] > BCD_MAX;
		end
	endgenerate
	assign bcd_bad = |digit_bad;

	// decode of the connector into the generator setup
	always_comb begin
		setup_d              = setup;
		setup_d.level        = pin_pos.level_n;
		setup_d.func_current = pin_pos.func_n;
		setup_d.range        = bpr_range_e'(pin_pos.range_n);
		setup_d.negative     = pin_pos.pol_n;
		setup_d.divider_on   = pin_pos.div_n;
		setup_d.operate      = pin_pos.operate_standby_request_n;
		case (pin_pos.vlim_n)
			2'b00:   setup_d.vlimit_v = VLIM_0;
			2'b01:   setup_d.vlimit_v = VLIM_1;
			2'b10:   setup_d.vlimit_v = VLIM_2;
			default: setup_d.vlimit_v = VLIM_3;
		endcase
		case (pin_pos.ilim_n)
			2'b00:   setup_d.ilimit_ma = ILIM_0;
			2'b01:   setup_d.ilimit_ma = ILIM_1;
			2'b10:   setup_d.ilimit_ma = ILIM_2;
			default: setup_d.ilimit_ma = ILIM_3;
		endcase
	end

	// setup is taken only in remote mode with all digits legal
	assign load          = remote_q && !bcd_bad;
	assign setup_changed = load && (setup_d != setup);
	assign limit_now     = limiter_active && setup.operate;

	// event sources and write-one-to-clear, set wins
	assign status_set[ST_TRIG]   = trig_evt;
	assign status_set[ST_LIMIT]  = limit_now && !limit_q;
	assign status_set[ST_BCDERR] = remote_q && bcd_bad;
	assign status_set[ST_CHANGE] = setup_changed;
	assign status_clr            = (wr_en && hit_status) ? pwdata[ST_W-1:0] : '0;
	assign status_d              = (status_q & ~status_clr) | status_set;
	// next mask, so irq tracks status and mask of the same cycle
	assign mask_d                = (wr_en && hit_mask) ? pwdata[ST_W-1:0] : mask_q;

	bpr_trig_qual u_trig (
		.pclk     (pclk),
		.presetn  (presetn),
		.trig_n   (trig_n),
		.trig_evt (trig_evt)
	);

	// connector sample stage; idle lines read as logical zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pin_q <= '1;
		end else begin
			pin_q <= pins_n;
		end
	end

	// generator setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			setup <= '0;
		end else if (load) begin
			setup <= setup_d;
		end
	end

	// software registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mask_q   <= MASK_RST;
			remote_q <= CTRL_RST;
			status_q <= '0;
		end else begin
			mask_q   <= mask_d;
			remote_q <= (wr_en && hit_ctrl) ? pwdata[0] : remote_q;
			status_q <= status_d;
		end
	end

	// scan toggle and connector flags, flags driven low when true
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			scan_run         <= 1'b0;
			limit_q          <= 1'b0;
			limit_flag_n     <= 1'b1;
			output_on_flag_n <= 1'b1;
			irq              <= 1'b0;
		end else begin
			scan_run         <= scan_run ^ trig_evt;
			limit_q          <= limit_now;
			limit_flag_n     <= ~limit_now;
			output_on_flag_n <= ~setup.operate;
			irq              <= |(status_d & mask_d);
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence s_remote_load;
		remote_q && !bcd_bad;
	endsequence

	a_limit_flag : assert property (limiter_active && setup.operate |=> !limit_flag_n)
		else $error("limiter flag not driven in operate");
	a_limit_idle : assert property (!setup.operate |=> limit_flag_n)
		else $error("limiter flag driven in standby");
	a_oper_flag : assert property (output_on_flag_n == !$past(setup.operate))
		else $error("operate flag does not follow output state");
	a_range_map : assert property (s_remote_load |=> setup.range == $past(~pin_q.range_n))
		else $error("range code not decoded");
	a_vlim_top : assert property (s_remote_load ##0 pin_q.vlim_n == 2'b00 |=> setup.vlimit_v == 11'h4E2)
		else $error("voltage limit code 11 not 1250 V");
	a_ilim_low : assert property (s_remote_load ##0 pin_q.ilim_n == 2'b11 |=> setup.ilimit_ma == 7'h05)
		else $error("current limit code 00 not 5 mA");
	a_level_take : assert property (s_remote_load |=> setup.level == $past(~pin_q.level_n))
		else $error("level digits not taken");
	a_div_line : assert property (s_remote_load |=> setup.divider_on == !$past(pin_q.div_n))
		else $error("divider line not applied");
	a_pin_sample : assert property (remote_q && !bcd_bad ##1 1 |=> $stable(setup) || $past(load))
		else $error("setup changed without load");
	a_scan_toggle : assert property (trig_evt |=> scan_run != $past(scan_run))
		else $error("scan did not toggle on trigger");
	a_local_hold : assert property (!remote_q |=> $stable(setup))
		else $error("setup changed in local mode");
	a_sticky_irq : assert property (irq == |(status_q & mask_q))
		else $error("interrupt does not match unmasked status");
endmodule : bpr_remote_port
`default_nettype wire

// >>> bpr_pkg.sv
// constants, types and decode tables for the parallel remote-control port
`default_nettype none
package bpr_pkg;
	// register byte offsets
	localparam logic [7:0] REG_STATUS = 8'h00;
	localparam logic [7:0] REG_MASK   = 8'h04;
	localparam logic [7:0] REG_LEVEL  = 8'h08;
	localparam logic [7:0] REG_SETUP  = 8'h0C;
	localparam logic [7:0] REG_CTRL   = 8'h10;
	// status and mask bit positions
	localparam int ST_TRIG   = 0;
	localparam int ST_LIMIT  = 1;
	localparam int ST_BCDERR = 2;
	localparam int ST_CHANGE = 3;
	localparam int ST_W      = 4;
	// setup readback field positions
	localparam int SU_FUNC   = 0;
	localparam int SU_RANGE  = 1;
	localparam int SU_NEG    = 3;
	localparam int SU_DIV    = 4;
	localparam int SU_OPER   = 5;
	localparam int SU_SCAN   = 6;
	localparam int SU_REMOTE = 7;
	localparam int SU_VLIM   = 8;
	localparam int SU_ILIM   = 19;
	// reset values
	localparam logic [ST_W-1:0] MASK_RST = 4'h0;
	localparam logic            CTRL_RST = 1'b0;
	// level digits
	localparam int N_DIGITS = 7;
	localparam int LEVEL_W  = 4 * N_DIGITS;
	localparam logic [3:0] BCD_MAX = 4'h9;
	// limit decode tables, volts and milliamps
	localparam int VLIM_W = 11;
	localparam int ILIM_W = 7;
	localparam logic [VLIM_W-1:0] VLIM_0 = 11'h00A;
	localparam logic [VLIM_W-1:0] VLIM_1 = 11'h082;
	localparam logic [VLIM_W-1:0] VLIM_2 = 11'h12C;
	localparam logic [VLIM_W-1:0] VLIM_3 = 11'h4E2;
	localparam logic [ILIM_W-1:0] ILIM_0 = 7'h05;
	localparam logic [ILIM_W-1:0] ILIM_1 = 7'h0D;
	localparam logic [ILIM_W-1:0] ILIM_2 = 7'h32;
	localparam logic [ILIM_W-1:0] ILIM_3 = 7'h7D;
	// trigger minimum width
	localparam int CLK_PERIOD_NS = 8;
	localparam int TRIG_MIN_NS   = 10000;
	localparam int TRIG_MIN_CYC  = (TRIG_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TRIG_CNT_W    = 11;

	typedef enum logic [1:0] {
		RNG_LOW  = 2'b00,
		RNG_MID  = 2'b01,
		RNG_HIGH = 2'b10,
		RNG_KV   = 2'b11
	} bpr_range_e;

	// raw connector lines, all active low
	typedef struct packed {
		logic [LEVEL_W-1:0] level_n;
		logic               func_n;
		logic [1:0]         range_n;
		logic               pol_n;
		logic               div_n;
		logic [1:0]         vlim_n;
		logic [1:0]         ilim_n;
		logic               operate_standby_request_n;
	} bpr_pins_s;

	// decoded setup handed to the generator
	typedef struct packed {
		logic [LEVEL_W-1:0] level;
		logic               func_current;
		bpr_range_e         range;
		logic               negative;
		logic               divider_on;
		logic [VLIM_W-1:0]  vlimit_v;
		logic [ILIM_W-1:0]  ilimit_ma;
		logic               operate;
	} bpr_setup_s;
endpackage : bpr_pkg
`default_nettype wire

// >>> bpr_trig_qual.sv
// trigger qualifier: fires once per low pulse held long enough
`timescale 1ns/1ps
`default_nettype none
module bpr_trig_qual (
	input  wire logic pclk,
	input  wire logic presetn,
	input  wire logic trig_n,
	output var  logic trig_evt
);
	import bpr_pkg::*;

	localparam logic [TRIG_CNT_W-1:0] CNT_TOP  = TRIG_CNT_W'(TRIG_MIN_CYC);
	localparam logic [TRIG_CNT_W-1:0] CNT_FIRE = TRIG_CNT_W'(TRIG_MIN_CYC - 1);

	logic [TRIG_CNT_W-1:0] cnt_q;
	logic [TRIG_CNT_W-1:0] cnt_d;
	logic                  trig_on;
	logic                  evt_d;

	// low level is the asserted trigger
	assign trig_on = ~trig_n;
	assign cnt_d   = !trig_on ? '0 : (cnt_q == CNT_TOP) ? cnt_q : cnt_q + 1'b1;
	assign evt_d   = trig_on && (cnt_q == CNT_FIRE);

	// width counter and event flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt_q    <= '0;
			trig_evt <= 1'b0;
		end else begin
			cnt_q    <= cnt_d;
			trig_evt <= evt_d;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	a_trig_width : assert property ($rose(trig_evt) |-> $past(cnt_q) == CNT_FIRE)
		else $error("trigger event without full pulse width");
	a_trig_high_idle : assert property (trig_n |=> !trig_evt)
		else $error("trigger event while line high");
endmodule : bpr_trig_qual
`default_nettype wire

// >>> bpr_ctrl_model.sv
// far-side controller model driving the negative-logic connector lines
`timescale 1ns/1ps
`default_nettype none
module bpr_ctrl_model (
	input  wire bpr_pkg::bpr_pins_s cmd,
	input  wire logic               trig_cmd,
	output var  bpr_pkg::bpr_pins_s pins_n,
	output var  logic               trig_n
);
	import bpr_pkg::*;
	// logical one leaves as a low level on every control line
	assign pins_n = ~cmd;
	// asserted trigger leaves as a low level
	assign trig_n = ~trig_cmd;
endmodule : bpr_ctrl_model
`default_nettype wire

// >>> bcd_parallel_remote_control_test.sv
// self-checking bench for the parallel remote-control port
`timescale 1ns/1ps
`default_nettype none
module bcd_parallel_remote_control_test;
	import bpr_pkg::*;
	localparam logic [VLIM_W-1:0] VT [4] = '{VLIM_0, VLIM_1, VLIM_2, VLIM_3};
	localparam logic [ILIM_W-1:0] IT [4] = '{ILIM_0, ILIM_1, ILIM_2, ILIM_3};
	logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
	logic [7:0]  paddr;
	logic [31:0] pwdata, prdata, rd;
	bpr_pins_s   cmd, pins_n;
	bpr_setup_s  setup;
	logic        trig_cmd, trig_n, limiter_active, scan_run, limit_flag_n;
	logic        output_on_flag_n, irq;
	logic [1:0]  c;
	logic [27:0] lvl;
	int          bad_count, total_checks;
	// clock generation
	initial pclk = 1'b0;
	always #4 pclk = ~pclk;
	bpr_ctrl_model ctl_u (.cmd(cmd), .trig_cmd(trig_cmd), .pins_n(pins_n), .trig_n(trig_n));
	bpr_remote_port dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .pins_n(pins_n), .trig_n(trig_n), .limiter_active(limiter_active),
		.setup(setup), .scan_run(scan_run), .limit_flag_n(limit_flag_n),
		.output_on_flag_n(output_on_flag_n), .irq(irq));
	// verdict and end of run
	task automatic close_out();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : close_out
	// compare seen against expected
	task automatic chk(input logic [63:0] s, input logic [63:0] e);
		total_checks++;
		if (s !== e) begin
			bad_count++;
			$display("BAD %0t seen %0h exp %0h", $time, s, e);
		end
	endtask : chk
	// one apb transfer; read data and error land in rd and er
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge pclk);
		psel   <= 1'b1;
		pwrite <= w;
		paddr  <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for pready at a rising edge; answer taken at that edge
		@(posedge pclk);
		while (pready !== 1'b1) begin
			n++;
			if (n > 16) begin
				bad_count++;
				close_out();
			end
			@(posedge pclk);
		end
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	// let edges pass, then sample settled outputs
	task automatic wt(input int n);
		repeat (n) @(posedge pclk);
		#1;
	endtask : wt
	// trigger held for n cycles, then released
	task automatic pulse(input int n);
		@(posedge pclk);
		trig_cmd <= 1'b1;
		repeat (n) @(posedge pclk);
		trig_cmd <= 1'b0;
		wt(4);
	endtask : pulse
	// hang guard
	initial begin
		repeat (100000) @(posedge pclk);
		bad_count++;
		close_out();
	end
	// main sequence
	initial begin
		bad_count = 0;
		total_checks = 0;
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		cmd = '0;
		trig_cmd = 1'b0;
		limiter_active = 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		wt(1);
		chk({output_on_flag_n, limit_flag_n, scan_run, irq}, 4'hC);
		apb(1'b0, REG_MASK, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, REG_CTRL, 32'h0);
		chk(rd, 32'h0);
		apb(1'b0, 8'h40, 32'h0);
		chk({rd, er}, {32'h0, 1'b1});
		apb(1'b1, 8'h44, 32'hFFFF_FFFF);
		chk(er, 1'b1);
		$display("test reset done");
		// lines ignored while remote is off
		@(posedge pclk);
		cmd <= '{28'h1, 1'b1, 2'h3, 1'b1, 1'b1, 2'h3, 2'h3, 1'b1};
		wt(4);
		chk({setup.operate, output_on_flag_n}, 2'b01);
		apb(1'b1, REG_CTRL, 32'h1);
		apb(1'b1, REG_STATUS, 32'hF);
		for (int i = 0; i < 4; i++) begin
			c = 2'(i);
			lvl = {4'h9, 4'h0, 16'h1234, 2'h0, c};
			@(posedge pclk);
			cmd <= '{lvl, c[0], c, c[1], ~c[0], c, ~c, 1'b1};
			wt(3);
			chk(setup.level, lvl);
			chk({setup.func_current, setup.range, setup.negative, setup.divider_on},
				{c[0], c, c[1], ~c[0]});
			chk({setup.vlimit_v, setup.ilimit_ma}, {VT[i], IT[3-i]});
			chk(output_on_flag_n, 1'b0);
			apb(1'b0, REG_SETUP, 32'h0);
			chk(rd[25:0], {IT[3-i], VT[i], 3'b101, ~c[0], c[1], c, c[0]});
			apb(1'b0, REG_LEVEL, 32'h0);
			chk(rd, {4'h0, lvl});
		end
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_CHANGE], 1'b1);
		apb(1'b1, REG_STATUS, 32'hF);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_W-1:0], 4'h0);
		$display("test decode done");
		// digit above nine refuses the whole word
		@(posedge pclk);
		cmd.level_n <= 28'h000000A;
		wt(3);
		chk(setup.level, lvl);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_BCDERR], 1'b1);
		@(posedge pclk);
		cmd.level_n <= 28'h0;
		wt(3);
		chk(setup.level, 28'h0);
		$display("test bcd done");
		// limiter flag and interrupt with remote off, then both flags in standby with remote on
		apb(1'b1, REG_CTRL, 32'h0);
		apb(1'b1, REG_MASK, 32'h1 << ST_LIMIT);
		apb(1'b0, REG_MASK, 32'h0);
		chk(rd, 32'h1 << ST_LIMIT);
		apb(1'b1, REG_STATUS, 32'hF);
		@(posedge pclk);
		limiter_active <= 1'b1;
		wt(3);
		chk({limit_flag_n, irq}, 2'b01);
		apb(1'b1, REG_STATUS, 32'h1 << ST_LIMIT);
		wt(2);
		chk(irq, 1'b0);
		apb(1'b1, REG_CTRL, 32'h1);
		@(posedge pclk);
		cmd.operate_standby_request_n <= 1'b0;
		wt(3);
		chk({limit_flag_n, output_on_flag_n}, 2'b11);
		@(posedge pclk);
		limiter_active <= 1'b0;
		$display("test limiter done");
		// short pulse ignored, long pulses start then pause
		pulse(1240);
		chk(scan_run, 1'b0);
		pulse(1260);
		chk(scan_run, 1'b1);
		apb(1'b0, REG_STATUS, 32'h0);
		chk(rd[ST_TRIG], 1'b1);
		pulse(1260);
		chk(scan_run, 1'b0);
		$display("test trigger done");
		close_out();
	end
endmodule : bcd_parallel_remote_control_test
`default_nettype wire
